// File: logic/sim_top.sv
// sim_top: supply integrity monitor, reset sequencing, warning flag, cause flags
// assumes analog comparators outside, cpu supplies mask and isr entry strobe
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - hold reset while supply under threshold
// - threshold level chosen by configuration
// - drive open-drain reset pin low
// - detector enabled by configuration, warning needs it
// - bit 5 tracks warning comparator, read-only
// - each warning flag change raises request while the enable bit is set
// - irq only when enabled and unmasked
// - pending cleared on service routine entry
// - no warning irq during reset delay
// - enable then crossing gives two irqs
// - enable after crossing gives one irq
// - wait keeps running, warning wakes wait only
// - halt freezes the control/status register
// - undervoltage flag set by lvd, write-zero clears
// - watchdog flag set by watchdog, cleared twice
// - other resets keep undervoltage flag
// - cause encoded in the two flags
// - bit 7 reads 0, bits 3:1 zero
// - bit 6 is warning interrupt enable
module sim_top (
    input  wire logic              core_clk,
    input  wire logic              rst,
    // configuration straps
    input  wire sim_pkg::sim_cfg_t cfg_in,
    // analog comparator outputs, high when supply is low
    input  wire logic              uv_cmp_low,
    input  wire logic              warn_cmp_low,
    // open-drain reset pin
    input  wire logic              rst_pin_in,
    output logic                   rst_pin_out,
    output logic                   rst_pin_oe,
    // watchdog underflow, one-cycle pulse
    input  wire logic              wdg_expire,
    // cpu handshake
    input  wire sim_pkg::sim_cpu_t cpu_in,
    // outputs to system and analog
    output logic                   sys_reset_r,
    output sim_pkg::sim_level_t    lvd_level_r,
    output logic                   lvd_enable_r,
    output logic                   warn_irq_r,
    output logic                   wake_req_r,
    // register port
    input  wire logic [15:0]       reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [7:0]        reg_rdata_r
);

    sim_pkg::sim_cfg_t       cfg_r;
    logic                    cfg_taken_r;
    logic [sim_pkg::SYNC_W-1:0] sync_q;
    logic                    uv_low;
    logic                    warn_low;
    logic                    pin_low;
    logic [3:0]              oe_hist_r;
    sim_pkg::sim_rst_state_t rs_r;
    sim_pkg::sim_rst_state_t rs_nxt;
    logic                    dly_start;
    logic                    dly_busy;
    logic                    lvd_evt;
    logic                    ext_evt;
    logic                    wdg_evt;
    logic                    in_reset;
    logic                    warn_ie_r;
    logic                    warn_flag_r;
    logic                    uv_flag_r;
    logic                    wdg_flag_r;
    logic                    pending_r;
    logic                    hit;
    logic                    wr_hit;
    logic                    frozen;
    logic                    flag_nxt;
    logic                    flag_toggle;
    logic                    ie_rise;
    logic [7:0]              sics_val;

    // configuration caught once after reset release
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cfg_r       <= '0;
            cfg_taken_r <= 1'b0;
        end else if (!cfg_taken_r) begin
            cfg_r       <= cfg_in;
            cfg_taken_r <= 1'b1;
        end
    end

    // threshold level to the analog detector
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            lvd_level_r  <= sim_pkg::LVL_LOW;
            lvd_enable_r <= 1'b0;
        end else begin
            lvd_level_r  <= cfg_r.level;
            lvd_enable_r <= cfg_r.lvd_enable;
        end
    end

    sim_sync #(
        .WIDTH (sim_pkg::SYNC_W),
        .INIT  (sim_pkg::SYNC_RESET)
    ) u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .async_in ({~rst_pin_in, warn_cmp_low, uv_cmp_low}),
        .sync_out (sync_q)
    );

    // detector and warning only when configured on
    assign uv_low   = sync_q[sim_pkg::LANE_UV] & cfg_r.lvd_enable & cfg_taken_r;
    assign warn_low = sync_q[sim_pkg::LANE_WARN] & cfg_r.lvd_enable & cfg_taken_r;
    // recent own drive, covers the synchroniser latency after release
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            oe_hist_r <= '1;
        end else begin
            oe_hist_r <= {oe_hist_r[2:0], rst_pin_oe};
        end
    end

    // own drive on the pin must not look like an external reset
    assign pin_low  = sync_q[sim_pkg::LANE_PIN] & ~rst_pin_oe & ~(|oe_hist_r);

    assign lvd_evt = uv_low;
    assign ext_evt = pin_low & ~uv_low;
    assign wdg_evt = wdg_expire & ~uv_low;

    // reset sequence: active phase, then delay, then run
    always_comb begin
        rs_nxt    = rs_r;
        dly_start = 1'b0;
        case (rs_r)
            sim_pkg::RS_RUN: begin
                if (lvd_evt || ext_evt || wdg_evt) begin
                    rs_nxt = sim_pkg::RS_ACTIVE;
                end
            end
            sim_pkg::RS_ACTIVE: begin
                if (!uv_low && !pin_low) begin
                    rs_nxt    = sim_pkg::RS_DELAY;
                    dly_start = 1'b1;
                end
            end
            sim_pkg::RS_DELAY: begin
                if (uv_low || pin_low) begin
                    rs_nxt = sim_pkg::RS_ACTIVE;
                end else if (!dly_busy) begin
                    rs_nxt = sim_pkg::RS_RUN;
                end
            end
            default: begin
                rs_nxt = sim_pkg::RS_ACTIVE;
            end
        endcase
    end

    // held in reset while supply low
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rs_r <= sim_pkg::RS_ACTIVE;
        end else if (!cfg_taken_r) begin
            rs_r <= sim_pkg::RS_ACTIVE;
        end else begin
            rs_r <= rs_nxt;
        end
    end

    sim_rst_delay u_delay (
        .core_clk (core_clk),
        .rst      (rst),
        .start    (dly_start),
        .long_sel (cfg_r.long_delay),
        .busy     (dly_busy)
    );

    assign in_reset = (rs_r != sim_pkg::RS_RUN) || (rs_nxt != sim_pkg::RS_RUN);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sys_reset_r <= 1'b1;
        end else begin
            sys_reset_r <= in_reset;
        end
    end

    // pin driven low while supply low and in delay, in active only when not held low from outside
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rst_pin_out <= 1'b0;
            rst_pin_oe  <= 1'b1;
        end else begin
            rst_pin_out <= 1'b0;
            rst_pin_oe  <= uv_low || (rs_r == sim_pkg::RS_DELAY)
                           || (rs_r == sim_pkg::RS_ACTIVE && !pin_low);
        end
    end

    // register access decode
    assign hit    = (reg_addr == sim_pkg::SICS_ADDR);
    assign wr_hit = reg_wr & hit;
    assign frozen = cpu_in.halt_mode;

    assign flag_nxt    = frozen ? warn_flag_r : warn_low;
    assign flag_toggle = flag_nxt != warn_flag_r;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            warn_flag_r <= 1'b0;
        end else begin
            warn_flag_r <= flag_nxt;
        end
    end

    // enable bit, cleared by any system reset
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            warn_ie_r <= 1'b0;
        end else if (in_reset) begin
            warn_ie_r <= 1'b0;
        end else if (wr_hit && !frozen) begin
            warn_ie_r <= reg_wdata[sim_pkg::BIT_WARN_IE];
        end
    end

    assign ie_rise = wr_hit && !frozen && !in_reset && !warn_ie_r
                     && reg_wdata[sim_pkg::BIT_WARN_IE];

    // toggles and enable edge set pending
    // nothing pends while reset holds the enable at zero
    // service entry clears, a new event wins
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pending_r <= 1'b0;
        end else if (in_reset) begin
            pending_r <= 1'b0;
        end else if ((flag_toggle && warn_ie_r) || ie_rise) begin
            pending_r <= 1'b1;
        end else if (cpu_in.isr_enter) begin
            pending_r <= 1'b0;
        end
    end

    // request gated by enable and cpu mask
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            warn_irq_r <= 1'b0;
        end else begin
            warn_irq_r <= pending_r && warn_ie_r && !cpu_in.irq_masked
                          && !cpu_in.isr_enter;
        end
    end

    // wakes from wait, never from halt
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wake_req_r <= 1'b0;
        end else begin
            wake_req_r <= pending_r && warn_ie_r && cpu_in.wait_mode
                          && !cpu_in.halt_mode;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            uv_flag_r <= sim_pkg::SICS_RESET[sim_pkg::BIT_UV_RST];
        end else if (lvd_evt) begin
            uv_flag_r <= 1'b1;
        end else if (wr_hit && !frozen && !reg_wdata[sim_pkg::BIT_UV_RST]) begin
            uv_flag_r <= 1'b0;
        end
    end

    // watchdog cause flag, lvd reset clears it
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wdg_flag_r <= sim_pkg::SICS_RESET[sim_pkg::BIT_WDG_RST];
        end else if (lvd_evt) begin
            wdg_flag_r <= 1'b0;
        end else if (wdg_evt) begin
            wdg_flag_r <= 1'b1;
        end else if (wr_hit && !frozen && !reg_wdata[sim_pkg::BIT_WDG_RST]) begin
            wdg_flag_r <= 1'b0;
        end
    end

    always_comb begin
        sics_val                          = '0;
        sics_val[sim_pkg::BIT_WARN_IE]    = warn_ie_r;
        sics_val[sim_pkg::BIT_WARN_FLAG]  = warn_flag_r;
        sics_val[sim_pkg::BIT_UV_RST]     = uv_flag_r;
        sics_val[sim_pkg::BIT_WDG_RST]    = wdg_flag_r;
        sics_val[sim_pkg::BIT_RSVD7]      = 1'b0;
    end

    // read data valid the cycle after the strobe, zero otherwise
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reg_rdata_r <= '0;
        end else if (reg_rd && hit) begin
            reg_rdata_r <= sics_val;
        end else begin
            reg_rdata_r <= '0;
        end
    end

endmodule : sim_top

`default_nettype wire

// File: logic/sim_pkg.sv
// sim_pkg: constants and types of the supply integrity monitor
// assumes one 100 MHz core clock and an 8-bit register port
package sim_pkg;

    // register map
    localparam logic [15:0] SICS_ADDR       = 16'h0025;
    localparam logic [7:0]  SICS_RESET      = 8'h00;
    localparam int          BIT_RSVD7       = 7;
    localparam int          BIT_WARN_IE     = 6;
    localparam int          BIT_WARN_FLAG   = 5;
    localparam int          BIT_UV_RST      = 4;
    localparam int          BIT_WDG_RST     = 0;

    // reset delay, in core clock cycles
    localparam int          DLY_SHORT_CYC   = 256;
    localparam int          DLY_LONG_CYC    = 4096;
    localparam int          DLY_W           = 13;
    localparam logic [DLY_W-1:0] DLY_SHORT  = DLY_W'(DLY_SHORT_CYC - 1);
    localparam logic [DLY_W-1:0] DLY_LONG   = DLY_W'(DLY_LONG_CYC - 1);

    // pin synchroniser lanes
    localparam int          SYNC_W          = 3;
    localparam int          LANE_UV         = 0;
    localparam int          LANE_WARN       = 1;
    localparam int          LANE_PIN        = 2;
    localparam logic [SYNC_W-1:0] SYNC_RESET = 3'h4;

    // detector threshold level
    typedef enum logic [1:0] {
        LVL_LOW  = 2'h0,
        LVL_MED  = 2'h1,
        LVL_HIGH = 2'h2
    } sim_level_t;

    // reset sequence states, gray along run -> active -> delay, both bits flip from delay -> run
    typedef enum logic [1:0] {
        RS_RUN    = 2'h0,
        RS_ACTIVE = 2'h1,
        RS_DELAY  = 2'h3
    } sim_rst_state_t;

    // non-volatile configuration
    typedef struct packed {
        logic       lvd_enable;
        sim_level_t level;
        logic       long_delay;
    } sim_cfg_t;

    // cpu side interrupt handshake
    typedef struct packed {
        logic irq_masked;
        logic isr_enter;
        logic wait_mode;
        logic halt_mode;
    } sim_cpu_t;

endpackage : sim_pkg

// File: logic/sim_sync.sv
// sim_sync: three-stage synchroniser, output moves once stages 2 and 3 agree
// assumes asynchronous inputs and the core clock domain
`timescale 1ns/100ps
`default_nettype none

module sim_sync #(
    parameter int                WIDTH = 1,
    parameter logic [WIDTH-1:0]  INIT  = '0
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] st1_r;
    logic [WIDTH-1:0] st2_r;
    logic [WIDTH-1:0] st3_r;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st1_r <= INIT;
            st2_r <= INIT;
            st3_r <= INIT;
        end else begin
            st1_r <= async_in;
            st2_r <= st1_r;
            st3_r <= st2_r;
        end
    end

    // per lane: take the new level only when stages agree
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sync_out <= INIT;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (st2_r[i] == st3_r[i]) begin
                    sync_out[i] <= st3_r[i];
                end
            end
        end
    end

endmodule : sim_sync

`default_nettype wire

// File: logic/sim_rst_delay.sv
// sim_rst_delay: reset delay counter, 256 or 4096 cycles
// assumes start is a one-cycle pulse from the sequencer
`timescale 1ns/100ps
`default_nettype none

module sim_rst_delay (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic start,
    input  wire logic long_sel,
    output logic      busy
);

    logic [sim_pkg::DLY_W-1:0] cnt_r;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
            busy  <= 1'b0;
        end else if (start) begin
            cnt_r <= long_sel ? sim_pkg::DLY_LONG : sim_pkg::DLY_SHORT;
            busy  <= 1'b1;
        end else if (busy) begin
            if (cnt_r == '0) begin
                busy <= 1'b0;
            end else begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end

endmodule : sim_rst_delay

`default_nettype wire

// File: verif/sim_chk.sv
// sim_chk: port-level assertions for the supply integrity monitor
// assumes it is bound into sim_top and sees only that module's ports
`timescale 1ns/100ps
`default_nettype none

module sim_chk (
    input wire logic              core_clk,
    input wire logic              rst,
    input wire logic              uv_cmp_low,
    input wire logic              warn_cmp_low,
    input wire logic              rst_pin_out,
    input wire logic              rst_pin_oe,
    input wire logic              wdg_expire,
    input wire sim_pkg::sim_cpu_t cpu_in,
    input wire logic              sys_reset_r,
    input wire logic              lvd_enable_r,
    input wire logic              warn_irq_r,
    input wire logic [15:0]       reg_addr,
    input wire logic              reg_rd,
    input wire logic [7:0]        reg_rdata_r
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    sequence rd_hit_s;
        reg_rd && reg_addr == sim_pkg::SICS_ADDR;
    endsequence
    // comparator settled long enough for the flag to follow
    sequence warn_steady_s;
        ($stable(warn_cmp_low) && lvd_enable_r && !cpu_in.halt_mode && !sys_reset_r) [*8];
    endsequence
    sequence uv_low_s;
        (lvd_enable_r && uv_cmp_low) [*8];
    endsequence

    rsvd_zero_a: assert property (
        reg_rdata_r[7] == 1'b0 && reg_rdata_r[3:1] == 3'h0)
        else $error("reserved register bits read nonzero");
    rdata_idle_a: assert property (
        !($past(reg_rd) && $past(reg_addr) == sim_pkg::SICS_ADDR) |-> reg_rdata_r == 8'h00)
        else $error("read data nonzero outside a register read");
    warn_track_a: assert property (
        warn_steady_s ##0 rd_hit_s |=> reg_rdata_r[5] == $past(warn_cmp_low))
        else $error("warning flag does not follow its comparator");
    uv_hold_a: assert property (
        uv_low_s |-> sys_reset_r)
        else $error("system left running with supply low");
    pin_low_a: assert property (
        uv_low_s |-> rst_pin_oe && !rst_pin_out)
        else $error("reset pin not pulled low during low supply");
    rst_delay_a: assert property (
        $fell(sys_reset_r) |-> $past(sys_reset_r, 250))
        else $error("reset released before the reset delay");
    irq_gate_a: assert property (
        warn_irq_r |-> !$past(cpu_in.irq_masked))
        else $error("interrupt request while masked");
    isr_clear_a: assert property (
        cpu_in.isr_enter |=> !warn_irq_r)
        else $error("interrupt request kept after service entry");
    wdg_reset_a: assert property (
        wdg_expire && !sys_reset_r |-> ##[1:6] sys_reset_r)
        else $error("watchdog expiry gave no system reset");
endmodule : sim_chk

bind sim_top sim_chk u_chk (
    .core_clk     (core_clk),
    .rst          (rst),
    .uv_cmp_low   (uv_cmp_low),
    .warn_cmp_low (warn_cmp_low),
    .rst_pin_out  (rst_pin_out),
    .rst_pin_oe   (rst_pin_oe),
    .wdg_expire   (wdg_expire),
    .cpu_in       (cpu_in),
    .sys_reset_r  (sys_reset_r),
    .lvd_enable_r (lvd_enable_r),
    .warn_irq_r   (warn_irq_r),
    .reg_addr     (reg_addr),
    .reg_rd       (reg_rd),
    .reg_rdata_r  (reg_rdata_r)
);

`default_nettype wire

// File: verif/sim_top_bench.sv
// sim_top_bench: self-checking bench for the supply integrity monitor
// assumes sim_pkg, sim_top and the bound checker are compiled before it
`timescale 1ns/100ps
`default_nettype none

module sim_top_bench;
    logic                core_clk = 1'b0;
    logic                rst      = 1'b1;
    sim_pkg::sim_cfg_t   cfg      = '{1'b1, sim_pkg::LVL_LOW, 1'b0};
    sim_pkg::sim_cpu_t   cpu      = '0;
    logic                uv = 1'b0, warn = 1'b0, ext = 1'b0, wdg = 1'b0;
    logic                wr = 1'b0, rd = 1'b0, irq_d = 1'b0;
    logic [15:0]         addr     = 16'h0000;
    logic [7:0]          wdata    = 8'h00;
    logic                pin_out, pin_oe, sys_rst, lvd_en, irq, wake;
    sim_pkg::sim_level_t level;
    logic [7:0]          rdata;
    wire logic           pin_lvl;
    int                  mismatches = 0, n_checks = 0, cycles = 0, irq_cnt = 0;
    int                  m_ie = 0, m_warn = 0, m_uv = 0, m_wdg = 0, m_irq = 0;
    localparam logic [15:0] A = sim_pkg::SICS_ADDR;

    // open-drain pin with pull-up
    assign pin_lvl = !((pin_oe && !pin_out) || ext);

    sim_top uut (
        .core_clk(core_clk), .rst(rst), .cfg_in(cfg), .uv_cmp_low(uv),
        .warn_cmp_low(warn), .rst_pin_in(pin_lvl), .rst_pin_out(pin_out),
        .rst_pin_oe(pin_oe), .wdg_expire(wdg), .cpu_in(cpu), .sys_reset_r(sys_rst),
        .lvd_level_r(level), .lvd_enable_r(lvd_en), .warn_irq_r(irq),
        .wake_req_r(wake), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
        .reg_rd(rd), .reg_rdata_r(rdata)
    );

    always #5 core_clk = ~core_clk;

    // hang limit and interrupt pulse count
    always @(posedge core_clk) begin
        cycles++;
        irq_d <= irq;
        if (irq === 1'b1 && irq_d !== 1'b1) irq_cnt++;
        if (cycles == 30000) begin
            mismatches++;
            results();
        end
    end

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk8

    function automatic logic [7:0] m_reg();
        return {1'b0, m_ie[0], m_warn[0], m_uv[0], 3'h0, m_wdg[0]};
    endfunction : m_reg

    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : step

    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [15:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge core_clk);
        rd <= 1'b0;
        #1;
        chk8(rdata, exp);
    endtask : rd_reg

    task automatic cnt_chk();
        chk8(8'(irq_cnt), 8'(m_irq));
    endtask : cnt_chk

    task automatic wait_run();
        for (int i = 0; i < 5000 && sys_rst !== 1'b0; i++) @(posedge core_clk);
        #1;
        chk8({7'h0, sys_rst}, 8'h00);
        m_ie = 0;
    endtask : wait_run

    task automatic do_reset();
        @(posedge core_clk);
        rst <= 1'b1;
        step(12);
        chk8({5'h0, sys_rst, pin_oe, pin_out}, 8'h06);
        rst <= 1'b0;
        wait_run();
    endtask : do_reset

    task automatic set_warn(input int v);
        @(posedge core_clk);
        warn <= v[0];
        step(10);
        if (m_ie == 1 && v != m_warn) m_irq++;
        m_warn = v;
    endtask : set_warn

    task automatic isr();
        @(posedge core_clk);
        cpu.isr_enter <= 1'b1;
        @(posedge core_clk);
        cpu.isr_enter <= 1'b0;
        #1;
        chk8({7'h0, irq}, 8'h00);
    endtask : isr

    // kind 0 watchdog, 1 low supply with a warning dip held 30 cycles past it, 2 external pin
    task automatic evt(input int kind);
        @(posedge core_clk);
        wdg <= (kind == 0);
        uv <= (kind == 1);
        warn <= (kind == 1);
        ext <= (kind == 2);
        @(posedge core_clk);
        wdg <= 1'b0;
        step(20);
        if (kind == 1) chk8({5'h0, sys_rst, pin_oe, pin_out}, 8'h06);
        uv <= 1'b0;
        ext <= 1'b0;
        step(30);
        warn <= 1'b0;
        wait_run();
        if (kind == 1) m_uv = 1;
        m_wdg = (kind == 0) ? 1 : (kind == 1) ? 0 : m_wdg;
        rd_reg(A, m_reg());
        cnt_chk();
    endtask : evt

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results

    initial begin
        void'($urandom(32'h69f7));
        for (int l = 0; l < 3; l++) begin
            cfg.level = sim_pkg::sim_level_t'(l);
            do_reset();
            chk8({6'h0, level}, 8'(l));
            chk8({7'h0, lvd_en}, 8'h01);
        end
        cfg = '{1'b0, sim_pkg::LVL_MED, 1'b1};
        do_reset();
        chk8({7'h0, lvd_en}, 8'h00);
        uv <= 1'b1;
        step(20);
        chk8({7'h0, sys_rst}, 8'h00);
        uv <= 1'b0;
        rd_reg(A, 8'h00);
        $display("test config done");
        cfg = '{1'b1, sim_pkg::LVL_MED, 1'b0};
        do_reset();
        rd_reg(A, 8'h00);
        addr = 16'h0026 + 16'($urandom_range(0, 16'h0fff));
        wr_reg(addr, 8'($urandom));
        rd_reg(addr, 8'h00);
        set_warn(1);
        rd_reg(A, m_reg());
        cnt_chk();
        wr_reg(A, 8'h51);
        m_ie = 1;
        m_irq++;
        step(4);
        cnt_chk();
        rd_reg(A, m_reg());
        isr();
        set_warn(0);
        cnt_chk();
        isr();
        cpu.irq_masked <= 1'b1;
        set_warn(1);
        chk8({7'h0, irq}, 8'h00);
        cpu.irq_masked <= 1'b0;
        step(4);
        cnt_chk();
        isr();
        cpu.wait_mode <= 1'b1;
        set_warn(0);
        chk8({7'h0, wake}, 8'h01);
        cnt_chk();
        isr();
        cpu.wait_mode <= 1'b0;
        cpu.halt_mode <= 1'b1;
        warn <= 1'b1;
        step(10);
        wr_reg(A, 8'h00);
        rd_reg(A, m_reg());
        chk8({7'h0, wake}, 8'h00);
        cnt_chk();
        cpu.halt_mode <= 1'b0;
        step(10);
        m_warn = 1;
        m_irq++;
        cnt_chk();
        rd_reg(A, m_reg());
        isr();
        set_warn(0);
        isr();
        $display("test register and interrupt done");
        evt(0);
        evt(1);
        evt(2);
        evt(0);
        wr_reg(A, 8'h00);
        m_uv = 0;
        m_wdg = 0;
        rd_reg(A, m_reg());
        evt(2);
        $display("test reset causes done");
        results();
    end
endmodule : sim_top_bench

`default_nettype wire
